/* core/charger_reset_pkg.sv */
package charger_reset_pkg;

  // ==========
  // timing
  localparam int CLK_MHZ           = 200;
  localparam int LF_TICK_US        = 500;
  localparam int TICK_CYCLES       = LF_TICK_US * CLK_MHZ;
  localparam int PIN_FILTER_MIN_US = 1500;
  localparam int PIN_FILTER_TICKS  = PIN_FILTER_MIN_US / LF_TICK_US + 1;
  localparam int HOLD_TICKS        = 2;
  localparam int PROTECT_MS        = 2000;
  localparam int PROTECT_TICKS     = PROTECT_MS * 1000 / LF_TICK_US;
  localparam int POWER_OFF_MS      = 2400;
  localparam int POWER_OFF_TICKS   = POWER_OFF_MS * 1000 / LF_TICK_US;
  localparam int TICK_CNT_W        = 13;

  // ==========
  // register map (byte offsets)
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_FAST   = 5'h04;
  localparam logic [4:0] OFF_BREAK  = 5'h08;
  localparam logic [4:0] OFF_WDOG   = 5'h0c;
  localparam logic [4:0] OFF_KICK   = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;

  localparam int CTRL_CHG_EN_BIT   = 0;
  localparam int CTRL_WDOG_EN_BIT  = 1;
  localparam int CTRL_XTAL_CFG_BIT = 2;

  localparam int ST_MODE_LSB  = 0;
  localparam int ST_CV_BIT    = 3;
  localparam int ST_PROT_BIT  = 4;
  localparam int ST_WARM_BIT  = 5;
  localparam int ST_ERR_BIT   = 6;
  localparam int ST_CAUSE_LSB = 8;

  localparam int CAUSE_POR    = 0;
  localparam int CAUSE_PIN    = 1;
  localparam int CAUSE_ATTACH = 2;
  localparam int CAUSE_BREAK  = 3;
  localparam int CAUSE_WDOG   = 4;
  localparam int NUM_CAUSES   = 5;

  // reset values, fast-current limits and trickle divider
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [7:0]  FAST_MA_MIN = 8'h0a;
  localparam logic [7:0]  FAST_MA_MAX = 8'hc8;
  localparam logic [7:0]  FAST_RESET  = 8'h64;
  localparam logic [7:0]  TRICKLE_DIV = 8'h0a;
  localparam logic [15:0] BREAK_RESET = 16'h0000;
  localparam logic [15:0] WDOG_RESET  = 16'h0000;

  // synchroniser lanes
  localparam int SY_RST_N   = 0;
  localparam int SY_RX      = 1;
  localparam int SY_REGEN   = 2;
  localparam int SY_CHG     = 3;
  localparam int SY_XTAL    = 4;
  localparam int SY_FAST_HI = 5;
  localparam int SY_FAST_LO = 6;
  localparam int SY_FLOAT   = 7;
  localparam int SY_HYST    = 8;
  localparam int SY_TERM    = 9;
  localparam int SY_NEAR    = 10;
  localparam int NUM_SYNC   = 11;
  localparam logic [NUM_SYNC-1:0] SYNC_RESET = 11'h003;

  typedef enum logic [2:0] {
    MODE_DISABLED = 3'b000,
    MODE_TRICKLE  = 3'b001,
    MODE_FAST     = 3'b010,
    MODE_STANDBY  = 3'b011,
    MODE_ERROR    = 3'b100
  } charger_mode_e;

  typedef enum logic [1:0] {
    RS_RUN  = 2'b00,
    RS_HOLD = 2'b01,
    RS_OFF  = 2'b10
  } reset_state_e;

endpackage

/* core/lf_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module lf_tick_gen #(
  parameter int TICK_CYCLES = 100000
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam int CW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick period must be at least two cycles");
  end

  logic [CW-1:0] count_reg;

  // free-running divider, one-cycle enable at wrap
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count_reg <= '0;
      tick_out  <= 1'b0;
    end else if (count_reg == CW'(TICK_CYCLES - 1)) begin
      count_reg <= '0;
      tick_out  <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick_out  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* core/charger_mode_and_reset_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module charger_mode_and_reset_ctrl #(
  parameter int TICK_CYCLES = charger_reset_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        reset_pin_n_in,
  input  wire logic        serial_receive_pin_in,
  input  wire logic        regulator_enable_pin_in,
  input  wire logic        charger_present_in,
  input  wire logic        crystal_present_in,
  input  wire logic        bat_above_fast_hi_in,
  input  wire logic        bat_above_fast_lo_in,
  input  wire logic        bat_at_float_in,
  input  wire logic        bat_below_float_hyst_in,
  input  wire logic        current_below_term_in,
  input  wire logic        bat_near_charger_in,
  output logic      [2:0]  charger_mode_out,
  output logic             charge_enable_out,
  output logic             cv_regulate_out,
  output logic      [7:0]  charge_current_ma_out,
  output logic             charger_error_event_out,
  output logic             core_reset_out,
  output logic             warm_reset_out,
  output logic             protect_active_out,
  output logic             power_hold_out,
  output logic             pins_hiz_out,
  output logic      [2:0]  pull_strong_up_out,
  output logic             pull_weak_up_out,
  output logic      [2:0]  pull_weak_down_out,
  output logic             xtal_assume_max_out,
  output logic             osc_free_run_out
);

  import charger_reset_pkg::*;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick period must be at least two cycles");
  end

  // ==========
  // input synchronisers and slow tick
  logic [NUM_SYNC-1:0] sync_meta_reg;
  logic [NUM_SYNC-1:0] sync_reg;
  logic                tick;

  // two flops per asynchronous input
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_meta_reg <= SYNC_RESET;
      sync_reg      <= SYNC_RESET;
    end else begin
      sync_meta_reg <= {bat_near_charger_in, current_below_term_in, bat_below_float_hyst_in,
                        bat_at_float_in, bat_above_fast_lo_in, bat_above_fast_hi_in,
                        crystal_present_in, charger_present_in, regulator_enable_pin_in,
                        serial_receive_pin_in, reset_pin_n_in};
      sync_reg      <= sync_meta_reg;
    end
  end

  lf_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tick_out    (tick)
  );

  logic regen_prev_reg;
  logic chg_prev_reg;
  logic regen_rise;
  logic chg_rise;

  // edge history for power-on and attach
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      regen_prev_reg <= 1'b0;
      chg_prev_reg   <= 1'b0;
    end else begin
      regen_prev_reg <= sync_reg[SY_REGEN];
      chg_prev_reg   <= sync_reg[SY_CHG];
    end
  end

  assign regen_rise = sync_reg[SY_REGEN] & ~regen_prev_reg;
  assign chg_rise   = sync_reg[SY_CHG] & ~chg_prev_reg;

  // ==========
  // avalon slave
  logic                  wait_reg;
  logic [31:0]           rdata_reg;
  logic [2:0]            ctrl_reg;
  logic [7:0]            fast_ma_reg;
  logic [15:0]           break_ticks_reg;
  logic [15:0]           wdog_ticks_reg;
  logic                  err_sticky_reg;
  logic [NUM_CAUSES-1:0] cause_reg;
  logic                  wr_en;
  logic                  kick;
  reset_state_e          rs_state_reg;
  reset_state_e          rs_next;
  charger_mode_e         mode_reg;
  charger_mode_e         mode_next;
  logic                  warm_reg;
  logic                  core_reset_reg;
  logic [TICK_CNT_W-1:0] protect_cnt_reg;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [7:0] clamp_fast(input logic [31:0] value);
    if (value < 32'(FAST_MA_MIN)) clamp_fast = FAST_MA_MIN;
    else if (value > 32'(FAST_MA_MAX)) clamp_fast = FAST_MA_MAX;
    else clamp_fast = value[7:0];
  endfunction

  assign wr_en = avs_write_in & ~wait_reg;
  assign kick  = wr_en & hit(avs_address_in, OFF_KICK);

  // one wait cycle, then answer for one cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wait_reg <= 1'b1;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (avs_read_in | avs_write_in) begin
      wait_reg <= 1'b0;
    end
  end

  // read data latched while waitrequest is high
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && wait_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (hit(avs_address_in, OFF_CTRL))   rdata_reg[2:0]  <= ctrl_reg;
      if (hit(avs_address_in, OFF_FAST))   rdata_reg[7:0]  <= fast_ma_reg;
      if (hit(avs_address_in, OFF_BREAK))  rdata_reg[15:0] <= break_ticks_reg;
      if (hit(avs_address_in, OFF_WDOG))   rdata_reg[15:0] <= wdog_ticks_reg;
      if (hit(avs_address_in, OFF_STATUS)) begin
        rdata_reg[ST_MODE_LSB +: 3]          <= mode_reg;
        rdata_reg[ST_CV_BIT]                 <= cv_regulate_out;
        rdata_reg[ST_PROT_BIT]               <= protect_active_out;
        rdata_reg[ST_WARM_BIT]               <= warm_reg;
        rdata_reg[ST_ERR_BIT]                <= err_sticky_reg;
        rdata_reg[ST_CAUSE_LSB +: NUM_CAUSES] <= cause_reg;
      end
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  // configuration; a cold restart from off clears it
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rs_state_reg == RS_OFF) begin
      ctrl_reg        <= CTRL_RESET;
      fast_ma_reg     <= FAST_RESET;
      break_ticks_reg <= BREAK_RESET;
      wdog_ticks_reg  <= WDOG_RESET;
    end else if (wr_en) begin
      if (hit(avs_address_in, OFF_CTRL))  ctrl_reg <= avs_writedata_in[2:0];
      if (hit(avs_address_in, OFF_FAST))  fast_ma_reg <= clamp_fast(avs_writedata_in);
      if (hit(avs_address_in, OFF_BREAK)) break_ticks_reg <= avs_writedata_in[15:0];
      if (hit(avs_address_in, OFF_WDOG))  wdog_ticks_reg <= avs_writedata_in[15:0];
    end
  end

  // ==========
  // reset sources
  logic [TICK_CNT_W-1:0] pin_low_reg;
  logic [15:0]           brk_cnt_reg;
  logic [15:0]           wdog_cnt_reg;
  logic                  por_pending_reg;
  logic                  pin_req;
  logic                  pin_off;
  logic                  brk_req;
  logic                  wdog_req;
  logic                  attach_req;
  logic                  any_req;
  logic [TICK_CNT_W-1:0] hold_cnt_reg;

  // slow-tick samples of the low reset pin
  always_ff @(posedge core_clk_in) begin
    if (rst_in || sync_reg[SY_RST_N]) begin
      pin_low_reg <= '0;
    end else if (tick && pin_low_reg != '1) begin
      pin_low_reg <= pin_low_reg + 1'b1;
    end
  end

  assign pin_req = pin_low_reg >= TICK_CNT_W'(PIN_FILTER_TICKS);
  assign pin_off = pin_low_reg > TICK_CNT_W'(POWER_OFF_TICKS);

  // receive line held low
  always_ff @(posedge core_clk_in) begin
    if (rst_in || sync_reg[SY_RX]) begin
      brk_cnt_reg <= '0;
    end else if (tick && brk_cnt_reg != '1) begin
      brk_cnt_reg <= brk_cnt_reg + 1'b1;
    end
  end

  assign brk_req = (break_ticks_reg != 16'h0000) && (brk_cnt_reg >= break_ticks_reg);

  // watchdog, cleared by kick or while disabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in || kick || core_reset_reg || !ctrl_reg[CTRL_WDOG_EN_BIT]) begin
      wdog_cnt_reg <= '0;
    end else if (tick && wdog_cnt_reg != '1) begin
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
  end

  assign wdog_req = ctrl_reg[CTRL_WDOG_EN_BIT] && (wdog_ticks_reg != 16'h0000)
                    && (wdog_cnt_reg >= wdog_ticks_reg);
  assign attach_req = chg_rise;
  assign any_req    = pin_req | brk_req | wdog_req | attach_req | por_pending_reg;

  // ==========
  // reset sequencer
  always_comb begin
    rs_next = rs_state_reg;
    case (rs_state_reg)
      RS_RUN: begin
        if (any_req) rs_next = RS_HOLD;
      end
      RS_HOLD: begin
        if (pin_off) rs_next = RS_OFF;
        else if (!pin_req && !brk_req && hold_cnt_reg >= TICK_CNT_W'(HOLD_TICKS)) rs_next = RS_RUN;
      end
      RS_OFF: begin
        if (regen_rise || chg_rise) rs_next = RS_HOLD;
      end
      default: rs_next = RS_HOLD;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rs_state_reg   <= RS_HOLD;
      core_reset_reg <= 1'b1;
    end else begin
      rs_state_reg   <= rs_next;
      core_reset_reg <= (rs_next != RS_RUN);
    end
  end

  // minimum hold in reset, counted in slow ticks
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rs_state_reg != RS_HOLD) begin
      hold_cnt_reg <= '0;
    end else if (tick && hold_cnt_reg != '1) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  // power-on pending until the first hold is taken
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      por_pending_reg <= 1'b1;
      warm_reg        <= 1'b0;
    end else if (rs_state_reg == RS_OFF && rs_next == RS_HOLD) begin
      por_pending_reg <= 1'b0;
      warm_reg        <= 1'b0;
    end else if (rs_state_reg == RS_HOLD && por_pending_reg) begin
      por_pending_reg <= 1'b0;
      warm_reg        <= 1'b0;
    end else if (rs_state_reg == RS_RUN && rs_next == RS_HOLD) begin
      warm_reg        <= ~por_pending_reg;
    end
  end

  // sticky causes, set wins over write-one-clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cause_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CAUSES; i++) begin
        if (wr_en && hit(avs_address_in, OFF_STATUS) && avs_writedata_in[ST_CAUSE_LSB + i])
          cause_reg[i] <= 1'b0;
      end
      if (rs_state_reg == RS_RUN && rs_next == RS_HOLD) begin
        if (por_pending_reg) cause_reg[CAUSE_POR]    <= 1'b1;
        if (pin_req)         cause_reg[CAUSE_PIN]    <= 1'b1;
        if (attach_req)      cause_reg[CAUSE_ATTACH] <= 1'b1;
        if (brk_req)         cause_reg[CAUSE_BREAK]  <= 1'b1;
        if (wdog_req)        cause_reg[CAUSE_WDOG]   <= 1'b1;
      end
      if (rs_state_reg == RS_OFF && rs_next == RS_HOLD) cause_reg[CAUSE_POR] <= 1'b1;
      if (rs_state_reg == RS_HOLD && por_pending_reg) cause_reg[CAUSE_POR] <= 1'b1;
    end
  end

  // protection window after restart from an unexpected reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      protect_cnt_reg <= '0;
    end else if (rs_state_reg == RS_HOLD && rs_next == RS_RUN && warm_reg) begin
      protect_cnt_reg <= TICK_CNT_W'(PROTECT_TICKS);
    end else if (tick && protect_cnt_reg != '0) begin
      protect_cnt_reg <= protect_cnt_reg - 1'b1;
    end
  end

  // pin states follow the reset; oscillator free-runs while no crystal is present
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      core_reset_out      <= 1'b1;
      warm_reset_out      <= 1'b0;
      protect_active_out  <= 1'b0;
      power_hold_out      <= 1'b1;
      pins_hiz_out        <= 1'b1;
      pull_strong_up_out  <= 3'h7;
      pull_weak_up_out    <= 1'b1;
      pull_weak_down_out  <= 3'h7;
      xtal_assume_max_out <= 1'b1;
      osc_free_run_out    <= 1'b0;
    end else begin
      core_reset_out      <= core_reset_reg;
      warm_reset_out      <= warm_reg;
      protect_active_out  <= (protect_cnt_reg != '0);
      power_hold_out      <= (rs_state_reg != RS_OFF);
      pins_hiz_out        <= core_reset_reg;
      pull_strong_up_out  <= {3{core_reset_reg}};
      pull_weak_up_out    <= core_reset_reg;
      pull_weak_down_out  <= {3{core_reset_reg}};
      xtal_assume_max_out <= core_reset_reg | ~ctrl_reg[CTRL_XTAL_CFG_BIT];
      osc_free_run_out    <= ~sync_reg[SY_XTAL];
    end
  end

  // ==========
  // charger mode machine, evaluated every cycle
  always_comb begin
    mode_next = mode_reg;
    if (core_reset_reg || !ctrl_reg[CTRL_CHG_EN_BIT]) begin
      mode_next = MODE_DISABLED;
    end else if (sync_reg[SY_NEAR]) begin
      mode_next = MODE_ERROR;
    end else begin
      case (mode_reg)
        MODE_DISABLED, MODE_ERROR: begin
          mode_next = sync_reg[SY_FAST_HI] ? MODE_FAST : MODE_TRICKLE;
        end
        MODE_TRICKLE: begin
          if (sync_reg[SY_FAST_HI]) mode_next = MODE_FAST;
        end
        MODE_FAST: begin
          if (!sync_reg[SY_FAST_LO]) mode_next = MODE_TRICKLE;
          else if (sync_reg[SY_FLOAT] && sync_reg[SY_TERM]) mode_next = MODE_STANDBY;
        end
        MODE_STANDBY: begin
          if (sync_reg[SY_HYST]) mode_next = MODE_FAST;
        end
        default: mode_next = MODE_DISABLED;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_reg <= MODE_DISABLED;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // charge drive and status outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      charger_mode_out        <= MODE_DISABLED;
      charge_enable_out       <= 1'b0;
      cv_regulate_out         <= 1'b0;
      charge_current_ma_out   <= 8'h00;
      charger_error_event_out <= 1'b0;
    end else begin
      charger_mode_out        <= mode_next;
      charge_enable_out       <= (mode_next == MODE_TRICKLE) || (mode_next == MODE_FAST);
      cv_regulate_out         <= (mode_next == MODE_FAST) && sync_reg[SY_FLOAT];
      case (mode_next)
        MODE_TRICKLE: charge_current_ma_out <= fast_ma_reg / TRICKLE_DIV;
        MODE_FAST:    charge_current_ma_out <= fast_ma_reg;
        default:      charge_current_ma_out <= 8'h00;
      endcase
      charger_error_event_out <= (mode_next == MODE_ERROR) && (mode_reg != MODE_ERROR);
    end
  end

  // sticky error flag, set wins over write-one-clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      err_sticky_reg <= 1'b0;
    end else if (mode_next == MODE_ERROR && mode_reg != MODE_ERROR) begin
      err_sticky_reg <= 1'b1;
    end else if (wr_en && hit(avs_address_in, OFF_STATUS) && avs_writedata_in[ST_ERR_BIT]) begin
      err_sticky_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* testbench/charger_reset_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module charger_reset_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       reset_pin_n_in,
  input wire logic [2:0] charger_mode_out,
  input wire logic       charge_enable_out,
  input wire logic       cv_regulate_out,
  input wire logic [7:0] charge_current_ma_out,
  input wire logic       charger_error_event_out,
  input wire logic       core_reset_out,
  input wire logic       power_hold_out,
  input wire logic       pins_hiz_out,
  input wire logic [2:0] pull_strong_up_out,
  input wire logic       pull_weak_up_out,
  input wire logic [2:0] pull_weak_down_out,
  input wire logic       xtal_assume_max_out
);
  int unsigned low_cnt;
  // cycles the reset pin has been low
  always_ff @(posedge core_clk_in) begin
    if (rst_in || reset_pin_n_in) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_mode_legal; charger_mode_out <= 3'h4; endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("mode code out of range");
  property p_enable; charge_enable_out == (charger_mode_out inside {3'h1, 3'h2}); endproperty
  a_enable: assert property (p_enable)
    else $error("charge enable disagrees with mode");
  property p_no_current; charger_mode_out inside {3'h0, 3'h3, 3'h4} |->
    charge_current_ma_out == 8'h00; endproperty
  a_no_current: assert property (p_no_current)
    else $error("current while not charging");
  property p_fast_range; charger_mode_out == 3'h2 |->
    charge_current_ma_out inside {[8'h0a:8'hc8]}; endproperty
  a_fast_range: assert property (p_fast_range)
    else $error("fast current out of range");
  property p_trickle; charger_mode_out == 3'h1 |-> charge_current_ma_out <= 8'h14; endproperty
  a_trickle: assert property (p_trickle)
    else $error("trickle current too high");
  property p_cv; cv_regulate_out |-> charger_mode_out == 3'h2; endproperty
  a_cv: assert property (p_cv)
    else $error("voltage regulation outside fast mode");
  property p_err_event; charger_error_event_out |-> ##[0:1] charger_mode_out == 3'h4; endproperty
  a_err_event: assert property (p_err_event)
    else $error("error event without error mode");
  property p_pins; core_reset_out |-> pins_hiz_out && pull_weak_up_out &&
    pull_strong_up_out == 3'h7 && pull_weak_down_out == 3'h7 && xtal_assume_max_out; endproperty
  a_pins: assert property (p_pins)
    else $error("pin states wrong in reset");
  property p_off_in_reset; core_reset_out [*3] |-> charger_mode_out == 3'h0; endproperty
  a_off_in_reset: assert property (p_off_in_reset)
    else $error("charger active in reset");
  property p_pin_min; $rose(core_reset_out) && !reset_pin_n_in && power_hold_out |->
    low_cnt >= 3 * TICK_CYCLES; endproperty
  a_pin_min: assert property (p_pin_min)
    else $error("pin reset taken too early");
  property p_pin_max; low_cnt == 8 * TICK_CYCLES && power_hold_out |-> core_reset_out; endproperty
  a_pin_max: assert property (p_pin_max)
    else $error("pin reset taken too late");
  property p_power_off; $fell(power_hold_out) |-> low_cnt >= 4800 * TICK_CYCLES; endproperty
  a_power_off: assert property (p_power_off)
    else $error("powered off too early");
endmodule
bind charger_mode_and_reset_ctrl charger_reset_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .core_clk_in, .rst_in, .reset_pin_n_in, .charger_mode_out, .charge_enable_out,
  .cv_regulate_out, .charge_current_ma_out, .charger_error_event_out, .core_reset_out,
  .power_hold_out, .pins_hiz_out, .pull_strong_up_out, .pull_weak_up_out,
  .pull_weak_down_out, .xtal_assume_max_out);
`default_nettype wire

/* testbench/battery_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// battery and charger supply comparators
module battery_supply_model #(
  parameter int V_FAST  = 3000,
  parameter int V_HYST  = 100,
  parameter int V_FLOAT = 4200
) (
  input wire logic [12:0] bat_mv_in,
  input wire logic [12:0] chg_mv_in,
  input wire logic [12:0] taper_ma_in,
  input wire logic [7:0]  fast_ma_in,
  input wire logic [7:0]  current_ma_in,
  input wire logic        cv_in,
  output logic            fast_hi_out,
  output logic            fast_lo_out,
  output logic            at_float_out,
  output logic            below_float_hyst_out,
  output logic            below_term_out,
  output logic            near_charger_out
);
  logic [12:0] cur_ma;
  // current tapers once voltage is regulated
  assign cur_ma = cv_in ? taper_ma_in : {5'h00, current_ma_in};
  assign fast_hi_out = bat_mv_in > V_FAST;
  assign fast_lo_out = bat_mv_in > V_FAST - V_HYST;
  assign at_float_out = bat_mv_in >= V_FLOAT;
  assign below_float_hyst_out = bat_mv_in < V_FLOAT - V_HYST;
  assign below_term_out = 32'(cur_ma) * 10 < 32'(fast_ma_in);
  assign near_charger_out = bat_mv_in > chg_mv_in - 13'h032;
endmodule
`default_nettype wire

/* testbench/test_charger_mode_and_reset_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
// ==========
// bench top
module test_charger_mode_and_reset_ctrl;
  import charger_reset_pkg::*;
  localparam int TC = 10;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ev_seen = 1'b0;
  logic        pin_n = 1'b1, rx = 1'b1, regen = 1'b0, chg_p = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [12:0] bat = 13'h9c4, chg = 13'h1388, taper = 13'h032;
  logic [7:0]  cur;
  logic [2:0]  mode;
  logic        wreq, en, cv, ev, crst, warm, prot, hold, c_hi, c_lo, c_fl, c_bh, c_bt, c_nr;
  int          num_errors = 0, num_checks = 0, n;
  charger_mode_and_reset_ctrl #(.TICK_CYCLES(TC)) u_charger_mode_and_reset_ctrl (
    .core_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .reset_pin_n_in(pin_n), .serial_receive_pin_in(rx),
    .regulator_enable_pin_in(regen), .charger_present_in(chg_p), .crystal_present_in(1'b1),
    .bat_above_fast_hi_in(c_hi), .bat_above_fast_lo_in(c_lo), .bat_at_float_in(c_fl),
    .bat_below_float_hyst_in(c_bh), .current_below_term_in(c_bt), .bat_near_charger_in(c_nr),
    .charger_mode_out(mode), .charge_enable_out(en), .cv_regulate_out(cv),
    .charge_current_ma_out(cur), .charger_error_event_out(ev), .core_reset_out(crst),
    .warm_reset_out(warm), .protect_active_out(prot), .power_hold_out(hold),
    .pins_hiz_out(), .pull_strong_up_out(), .pull_weak_up_out(), .pull_weak_down_out(),
    .xtal_assume_max_out(), .osc_free_run_out());
  battery_supply_model u_battery_supply_model (
    .bat_mv_in(bat), .chg_mv_in(chg), .taper_ma_in(taper), .fast_ma_in(8'h3c),
    .current_ma_in(cur), .cv_in(cv), .fast_hi_out(c_hi), .fast_lo_out(c_lo),
    .at_float_out(c_fl), .below_float_hyst_out(c_bh), .below_term_out(c_bt),
    .near_charger_out(c_nr));
  // clock and error event latch
  always #2.5 clk = ~clk;
  always @(posedge clk) ev_seen <= ev_seen | ev;
  // one bus access, held until waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic lvl(input logic [12:0] b, input logic [12:0] c, input logic [12:0] t);
    @(posedge clk);
    bat <= b;
    chg <= c;
    taper <= t;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_crst(input logic v);
    n = 0;
    while (crst !== v && n < 1000) begin @(posedge clk); n++; end
    `CHK(crst, v)
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog on the whole run
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_crst(1'b0);
    rdchk(OFF_CTRL, 32'h0); rdchk(OFF_FAST, 32'h64); rdchk(5'h18, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0); `CHK(q[8], 1'b1)
    bus(1'b1, OFF_FAST, 32'h5); rdchk(OFF_FAST, 32'ha);
    bus(1'b1, OFF_FAST, 32'hfa); rdchk(OFF_FAST, 32'hc8);
    bus(1'b1, OFF_FAST, 32'h3c);
    lvl(13'h9c4, 13'h1388, 13'h032); `CHK(mode, 3'h0)
    bus(1'b1, OFF_CTRL, 32'h1); lvl(13'h9c4, 13'h1388, 13'h032); `CHK({mode, cur}, 11'h106)
    lvl(13'hb86, 13'h1388, 13'h032); `CHK(mode, 3'h1)
    lvl(13'hbea, 13'h1388, 13'h032); `CHK({mode, cur, en}, 12'h479)
    lvl(13'hb86, 13'h1388, 13'h032); `CHK(mode, 3'h2)
    lvl(13'hb22, 13'h1388, 13'h032); `CHK(mode, 3'h1)
    lvl(13'h1068, 13'h1388, 13'h032); `CHK({mode, cv}, 4'h5)
    lvl(13'h1068, 13'h1388, 13'h005); `CHK({mode, cur}, 11'h300)
    lvl(13'hfd2, 13'h1388, 13'h005); `CHK(mode, 3'h2)
    lvl(13'hfd2, 13'hfa0, 13'h005); `CHK({mode, cur, ev_seen}, 12'h801)
    lvl(13'hfd2, 13'h1388, 13'h005); `CHK(mode, 3'h2)
    $display("charger modes done");
    @(posedge clk) pin_n <= 1'b0;
    repeat (20) @(posedge clk);
    pin_n <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(crst, 1'b0)
    @(posedge clk) pin_n <= 1'b0;
    wait_crst(1'b1);
    repeat (110) @(posedge clk);
    pin_n <= 1'b1;
    wait_crst(1'b0);
    `CHK({warm, prot}, 2'h3)
    rdchk(OFF_CTRL, 32'h1);
    bus(1'b0, OFF_STATUS, 32'h0); `CHK(q[9], 1'b1)
    chg_p <= 1'b0;
    repeat (5) @(posedge clk);
    chg_p <= 1'b1;
    wait_crst(1'b1); wait_crst(1'b0); bus(1'b0, OFF_STATUS, 32'h0); `CHK(q[10], 1'b1)
    bus(1'b1, OFF_BREAK, 32'h3);
    rx <= 1'b0;
    wait_crst(1'b1);
    rx <= 1'b1;
    wait_crst(1'b0); bus(1'b1, OFF_BREAK, 32'h0); bus(1'b0, OFF_STATUS, 32'h0); `CHK(q[11], 1'b1)
    bus(1'b1, OFF_WDOG, 32'h5); bus(1'b1, OFF_CTRL, 32'h3);
    wait_crst(1'b1); wait_crst(1'b0); bus(1'b1, OFF_CTRL, 32'h1);
    bus(1'b0, OFF_STATUS, 32'h0); `CHK(q[12], 1'b1)
    $display("reset sources done");
    @(posedge clk) pin_n <= 1'b0;
    n = 0;
    while (hold !== 1'b0 && n < 50000) begin @(posedge clk); n++; end
    `CHK(hold, 1'b0)
    pin_n <= 1'b1;
    repeat (100) @(posedge clk);
    `CHK(hold, 1'b0)
    regen <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(hold, 1'b1)
    wait_crst(1'b0); `CHK(warm, 1'b0)
    rdchk(OFF_CTRL, 32'h0);
    $display("power off done");
    stop_test();
  end
endmodule
`default_nettype wire
